/* File: hw/seq_pkg.sv */
// Shared constants, codes and carrier types for the checksum and security sequencer
package seq_pkg;

  // Status codes returned in a status frame
  localparam logic [7:0] ACK_CODE = 8'h06;
  localparam logic [7:0] PARAM_ERR_CODE = 8'h05;
  localparam logic [7:0] SUM_ERR_CODE = 8'h07;
  localparam logic [7:0] NACK_CODE = 8'h15;
  localparam logic [7:0] MARGIN_A_CODE = 8'h1A;
  localparam logic [7:0] MARGIN_B_CODE = 8'h1B;
  localparam logic [7:0] WRITE_FAIL_CODE = 8'h1C;
  localparam logic [7:0] NO_ERR = 8'h00;

  // Framing constants
  localparam logic [7:0] ETX_BYTE = 8'h03;
  localparam logic [7:0] CSUM_CMD_LEN = 8'h07;
  localparam logic [7:0] SEC_CMD_LEN = 8'h03;
  localparam logic [7:0] SEC_DATA_LEN = 8'h06;
  localparam logic [7:0] STATUS_LEN = 8'h01;
  localparam logic [7:0] SUM_DATA_LEN = 8'h02;
  localparam logic [7:0] BOOT_REQUIRED = 8'h01;
  localparam int PAYLOAD_MAX = 8;

  // Payload field positions
  localparam int POS_CODE = 0;
  localparam int POS_START_H = 1;
  localparam int POS_END_H = 4;
  localparam int POS_SEC_FLAGS = 0;
  localparam int POS_SEC_BOOT = 1;
  localparam int POS_WIN_START_H = 2;
  localparam int POS_WIN_END_H = 4;

  // Programmer-side waits, kept here for the bench
  localparam int CLK_MHZ = 250;
  localparam int TCOM_US = 595;
  localparam int TFD4_US = 120;
  localparam int TCOM_CYCLES = TCOM_US * CLK_MHZ;
  localparam int TFD4_CYCLES = TFD4_US * CLK_MHZ;

  // One received frame as seen after its terminator
  typedef struct packed {
    logic etx_ok;
    logic sum_ok;
    logic is_data;
    logic [7:0] len;
    logic [PAYLOAD_MAX-1:0][7:0] pay;
  } frame_info_t;

  // One frame to send: a status frame or a two-byte data frame
  typedef struct packed {
    logic is_data;
    logic [7:0] status;
    logic [15:0] sum;
    logic [7:0] frame_sum;
  } reply_t;

  // Result of a security write or verify
  typedef enum logic [1:0] {OP_OK, OP_MARGIN_A, OP_MARGIN_B, OP_WRITE_FAIL} op_result_t;

  // Security settings handed to the flash engine
  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] boot;
    logic [15:0] win_start;
    logic [15:0] win_end;
  } sec_set_t;

endpackage

/* File: hw/frame_checker.sv */
// Byte-stream frame collector: length, payload, checksum and terminator checks
`timescale 1ns/100ps
module frame_checker import seq_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Received bytes
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_start,
  input wire logic rx_last,
  input wire logic rx_is_data,
  // Collected frame
  output frame_info_t info,
  output logic info_valid
);

  logic [7:0] idx_r, idx_nxt; // Position of the next byte
  logic [7:0] len_r, len_nxt; // Length field of the frame
  logic [7:0] acc_r, acc_nxt; // Running byte sum
  logic [PAYLOAD_MAX-1:0][7:0] pay_r, pay_nxt; // Payload store
  frame_info_t info_r, info_nxt; // Result held until the next frame ends
  logic vld_r, vld_nxt; // One-cycle result strobe

  // Next-state for collection; checksum byte joins the sum, terminator does not
  always_comb begin
    idx_nxt = idx_r;
    len_nxt = len_r;
    acc_nxt = acc_r;
    pay_nxt = pay_r;
    info_nxt = info_r;
    vld_nxt = 1'b0;
    if (rx_valid) begin
      if (rx_start) begin
        // Length byte opens the frame
        idx_nxt = 8'h01;
        len_nxt = rx_byte;
        acc_nxt = rx_byte;
        pay_nxt = '0;
      end else if (rx_last) begin
        // Terminator: a wrong position means the length field lied
        vld_nxt = 1'b1;
        info_nxt.etx_ok = (rx_byte == ETX_BYTE) && (idx_r == len_r + 8'h02);
        info_nxt.sum_ok = (acc_r == 8'h00);
        info_nxt.is_data = rx_is_data;
        info_nxt.len = len_r;
        info_nxt.pay = pay_r;
      end else begin
        // Payload bytes past the store are summed but not kept
        if (idx_r != 8'h00 && idx_r <= len_r && idx_r <= 8'h08) begin
          pay_nxt[3'(idx_r - 8'h01)] = rx_byte;
        end
        acc_nxt = acc_r + rx_byte;
        if (idx_r != 8'hFF) begin
          idx_nxt = idx_r + 8'h01;
        end
      end
    end
  end

  // Registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      idx_r <= '0;
      len_r <= '0;
      acc_r <= '0;
      pay_r <= '0;
      info_r <= '0;
      vld_r <= 1'b0;
    end else begin
      idx_r <= idx_nxt;
      len_r <= len_nxt;
      acc_r <= acc_nxt;
      pay_r <= pay_nxt;
      info_r <= info_nxt;
      vld_r <= vld_nxt;
    end
  end

  assign info = info_r;
  assign info_valid = vld_r;

endmodule // frame_checker

/* File: hw/csum_sec_sequencer.sv */
// Device-side sequencer for the checksum and security set commands
`timescale 1ns/100ps
module csum_sec_sequencer import seq_pkg::*; #(
  parameter int ADDR_W = 20,
  parameter logic [23:0] FLASH_BYTES = 24'h010000,
  parameter logic [23:0] BLOCK_BYTES = 24'h000400,
  parameter logic [7:0] CSUM_CMD_CODE = 8'hB0, // Arbitrary value
  parameter logic [7:0] SEC_CMD_CODE = 8'hA0, // Arbitrary value
  parameter logic [7:0] PROTECT_CODE = 8'h10
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Received frame bytes
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_start,
  input wire logic rx_last,
  input wire logic rx_is_data,
  // Frames to send
  output logic tx_valid,
  input wire logic tx_ready,
  output reply_t tx_frame,
  // Flash read port, data one cycle after the enable
  output logic flash_rd_en,
  output logic [ADDR_W-1:0] flash_rd_addr,
  input wire logic [7:0] flash_rd_data,
  // Security write and verify engine
  output logic sec_op_req,
  output logic sec_op_verify,
  output sec_set_t sec_settings,
  input wire logic sec_op_done,
  input wire op_result_t sec_op_result,
  input wire logic [7:0] cur_sec_flags,
  // Status
  output logic busy
);

  localparam logic [15:0] LAST_BLOCK = 16'((FLASH_BYTES / BLOCK_BYTES) - 24'h1);

  typedef enum {ST_IDLE, ST_SUM, ST_SEC_DATA, ST_SEC_WRITE, ST_SEC_VERIFY, ST_TX} state_t;

  frame_info_t info; // Last collected frame
  logic info_valid; // Strobe for that frame

  frame_checker u_frame_checker (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .rx_valid(rx_valid),
    .rx_byte(rx_byte),
    .rx_start(rx_start),
    .rx_last(rx_last),
    .rx_is_data(rx_is_data),
    .info(info),
    .info_valid(info_valid)
  );

  // Framing verdict: shape errors outrank checksum errors
  function automatic logic [7:0] frame_err(input frame_info_t f, input logic [7:0] exp_len);
    if (!f.etx_ok || f.len != exp_len) begin
      frame_err = NACK_CODE;
    end else if (!f.sum_ok) begin
      frame_err = SUM_ERR_CODE;
    end else begin
      frame_err = NO_ERR;
    end
  endfunction

  // Status frame with its own frame checksum
  function automatic reply_t mk_status(input logic [7:0] code);
    mk_status.is_data = 1'b0;
    mk_status.status = code;
    mk_status.sum = '0;
    mk_status.frame_sum = 8'h00 - STATUS_LEN - code;
  endfunction

  // Engine result to status code
  function automatic logic [7:0] op_code(input op_result_t r);
    case (r)
      OP_MARGIN_A: op_code = MARGIN_A_CODE;
      OP_MARGIN_B: op_code = MARGIN_B_CODE;
      OP_WRITE_FAIL: op_code = WRITE_FAIL_CODE;
      default: op_code = ACK_CODE;
    endcase
  endfunction

  // Decoded fields of the incoming frame
  logic [7:0] cmd_code;
  logic [23:0] rng_start, rng_end;
  logic [7:0] new_flags, new_boot;
  logic [15:0] win_start, win_end;
  logic range_bad, sec_param_bad, sec_protect;
  assign cmd_code = info.pay[POS_CODE];
  assign rng_start = {info.pay[POS_START_H], info.pay[POS_START_H+1], info.pay[POS_START_H+2]};
  assign rng_end = {info.pay[POS_END_H], info.pay[POS_END_H+1], info.pay[POS_END_H+2]};
  assign new_flags = info.pay[POS_SEC_FLAGS];
  assign new_boot = info.pay[POS_SEC_BOOT];
  assign win_start = {info.pay[POS_WIN_START_H], info.pay[POS_WIN_START_H+1]};
  assign win_end = {info.pay[POS_WIN_END_H], info.pay[POS_WIN_END_H+1]};
  // Range must sit inside flash and cover whole blocks
  assign range_bad = (rng_start > rng_end) || (rng_end >= FLASH_BYTES) ||
                     ((rng_start % BLOCK_BYTES) != 24'h0) ||
                     (((rng_end + 24'h1) % BLOCK_BYTES) != 24'h0);
  assign sec_param_bad = (new_boot != BOOT_REQUIRED) || (win_start > win_end) ||
                         (win_end > LAST_BLOCK);
  // A clear flag bit means prohibited; it may never come back
  assign sec_protect = |(~cur_sec_flags & new_flags);

  state_t state_r, state_nxt; // Sequence step
  state_t after_r, after_nxt; // Step taken once the pending frame is sent
  reply_t tx_r, tx_nxt; // Frame being offered
  logic tx_valid_r, tx_valid_nxt;
  logic pend_data_r, pend_data_nxt; // Data frame due after the status frame
  logic [23:0] addr_r, addr_nxt; // Next flash address to read
  logic [23:0] end_r, end_nxt; // Last address of the range
  logic issuing_r, issuing_nxt; // Reads still to issue
  logic rd_en_r, rd_en_nxt;
  logic rd_pend_r, rd_pend_nxt; // Read data arrives this cycle
  logic [15:0] sum_r, sum_nxt; // Flash byte sum
  logic op_req_r, op_req_nxt;
  logic op_verify_r, op_verify_nxt;
  sec_set_t set_r, set_nxt;
  logic [7:0] err;

  // Sequencer next-state: one frame in flight at a time
  always_comb begin
    state_nxt = state_r;
    after_nxt = after_r;
    tx_nxt = tx_r;
    tx_valid_nxt = tx_valid_r;
    pend_data_nxt = pend_data_r;
    addr_nxt = addr_r;
    end_nxt = end_r;
    issuing_nxt = issuing_r;
    rd_en_nxt = 1'b0;
    rd_pend_nxt = rd_en_r;
    sum_nxt = sum_r;
    op_req_nxt = 1'b0;
    op_verify_nxt = op_verify_r;
    set_nxt = set_r;
    err = NO_ERR;
    case (state_r)
      ST_IDLE: begin
        // Data frames and unknown commands belong to other handlers
        if (info_valid && !info.is_data && cmd_code == CSUM_CMD_CODE) begin
          err = frame_err(info, CSUM_CMD_LEN);
          if (err == NO_ERR && range_bad) begin
            err = PARAM_ERR_CODE;
          end
          if (err != NO_ERR) begin
            tx_nxt = mk_status(err);
            tx_valid_nxt = 1'b1;
            after_nxt = ST_IDLE;
            state_nxt = ST_TX;
          end else begin
            // Sum first so the status goes out with the data ready behind it
            addr_nxt = rng_start;
            end_nxt = rng_end;
            sum_nxt = '0;
            issuing_nxt = 1'b1;
            state_nxt = ST_SUM;
          end
        end else if (info_valid && !info.is_data && cmd_code == SEC_CMD_CODE) begin
          err = frame_err(info, SEC_CMD_LEN);
          tx_nxt = mk_status((err != NO_ERR) ? err : ACK_CODE);
          tx_valid_nxt = 1'b1;
          after_nxt = (err != NO_ERR) ? ST_IDLE : ST_SEC_DATA;
          state_nxt = ST_TX;
        end
      end
      ST_SUM: begin
        // Streaming reads; sum is a plain 16-bit byte total
        if (issuing_r) begin
          rd_en_nxt = 1'b1;
          if (addr_r == end_r) begin
            issuing_nxt = 1'b0;
          end else begin
            addr_nxt = addr_r + 24'h1;
          end
        end
        if (rd_pend_r) begin
          sum_nxt = sum_r + {8'h00, flash_rd_data};
        end
        if (!issuing_r && !rd_en_r && !rd_pend_r) begin
          tx_nxt = mk_status(ACK_CODE);
          tx_valid_nxt = 1'b1;
          pend_data_nxt = 1'b1;
          after_nxt = ST_IDLE;
          state_nxt = ST_TX;
        end
      end
      ST_SEC_DATA: begin
        if (info_valid && info.is_data) begin
          err = frame_err(info, SEC_DATA_LEN);
          if (err == NO_ERR && sec_param_bad) begin
            err = PARAM_ERR_CODE;
          end else if (err == NO_ERR && sec_protect) begin
            err = PROTECT_CODE;
          end
          if (err != NO_ERR) begin
            tx_nxt = mk_status(err);
            tx_valid_nxt = 1'b1;
            after_nxt = ST_IDLE;
            state_nxt = ST_TX;
          end else begin
            set_nxt.flags = new_flags;
            set_nxt.boot = new_boot;
            set_nxt.win_start = win_start;
            set_nxt.win_end = win_end;
            op_req_nxt = 1'b1;
            op_verify_nxt = 1'b0;
            state_nxt = ST_SEC_WRITE;
          end
        end else if (info_valid) begin
          // A command in place of the data frame abandons the sequence
          state_nxt = ST_IDLE;
        end
      end
      ST_SEC_WRITE: begin
        if (sec_op_done) begin
          tx_nxt = mk_status(op_code(sec_op_result));
          tx_valid_nxt = 1'b1;
          after_nxt = (sec_op_result == OP_OK) ? ST_SEC_VERIFY : ST_IDLE;
          state_nxt = ST_TX;
        end
      end
      ST_SEC_VERIFY: begin
        if (sec_op_done) begin
          tx_nxt = mk_status(op_code(sec_op_result));
          tx_valid_nxt = 1'b1;
          after_nxt = ST_IDLE;
          state_nxt = ST_TX;
        end
      end
      ST_TX: begin
        if (tx_ready) begin
          if (pend_data_r) begin
            // Frame checksum always matches what is sent
            tx_nxt.is_data = 1'b1;
            tx_nxt.status = ACK_CODE;
            tx_nxt.sum = sum_r;
            tx_nxt.frame_sum = 8'h00 - SUM_DATA_LEN - sum_r[15:8] - sum_r[7:0];
            pend_data_nxt = 1'b0;
          end else begin
            tx_valid_nxt = 1'b0;
            state_nxt = after_r;
            if (after_r == ST_SEC_VERIFY) begin
              op_req_nxt = 1'b1;
              op_verify_nxt = 1'b1;
            end
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      after_r <= ST_IDLE;
      tx_r <= '0;
      tx_valid_r <= 1'b0;
      pend_data_r <= 1'b0;
      addr_r <= '0;
      end_r <= '0;
      issuing_r <= 1'b0;
      rd_en_r <= 1'b0;
      rd_pend_r <= 1'b0;
      sum_r <= '0;
      op_req_r <= 1'b0;
      op_verify_r <= 1'b0;
      set_r <= '0;
    end else begin
      state_r <= state_nxt;
      after_r <= after_nxt;
      tx_r <= tx_nxt;
      tx_valid_r <= tx_valid_nxt;
      pend_data_r <= pend_data_nxt;
      addr_r <= addr_nxt;
      end_r <= end_nxt;
      issuing_r <= issuing_nxt;
      rd_en_r <= rd_en_nxt;
      rd_pend_r <= rd_pend_nxt;
      sum_r <= sum_nxt;
      op_req_r <= op_req_nxt;
      op_verify_r <= op_verify_nxt;
      set_r <= set_nxt;
    end
  end

  // Read address follows the issue pointer
  logic [ADDR_W-1:0] rd_addr_r;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_addr_r <= '0;
    end else if (rd_en_nxt) begin
      rd_addr_r <= addr_r[ADDR_W-1:0];
    end
  end

  assign tx_valid = tx_valid_r;
  assign tx_frame = tx_r;
  assign flash_rd_en = rd_en_r;
  assign flash_rd_addr = rd_addr_r;
  assign sec_op_req = op_req_r;
  assign sec_op_verify = op_verify_r;
  assign sec_settings = set_r;
  assign busy = (state_r != ST_IDLE);

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  logic csum_cmd, sec_cmd_idle, sec_dat;
  assign csum_cmd = info_valid && !info.is_data && state_r == ST_IDLE && cmd_code == CSUM_CMD_CODE;
  assign sec_cmd_idle = info_valid && !info.is_data && state_r == ST_IDLE &&
                        cmd_code == SEC_CMD_CODE;
  assign sec_dat = info_valid && info.is_data && state_r == ST_SEC_DATA &&
                   info.etx_ok && info.sum_ok && info.len == SEC_DATA_LEN;

  sequence s_write_ok;
    state_r == ST_SEC_WRITE && sec_op_done && sec_op_result == OP_OK;
  endsequence
  sequence s_ack_to_verify;
    tx_valid_r && tx_r.status == ACK_CODE && after_r == ST_SEC_VERIFY;
  endsequence

  bad_frame_nack_a: assert property (csum_cmd && !info.etx_ok |=>
    tx_valid && tx_frame.status == NACK_CODE) else $error("malformed frame not refused");
  sec_sum_err_a: assert property (sec_cmd_idle && info.etx_ok &&
    info.len == SEC_CMD_LEN && !info.sum_ok |=> tx_valid && tx_frame.status == SUM_ERR_CODE)
    else $error("no sum error");
  // The refusal is being offered, so the sequencer is busy sending it
  range_param_a: assert property (csum_cmd && info.etx_ok && info.sum_ok &&
    info.len == CSUM_CMD_LEN && range_bad |=> tx_valid && tx_frame.status == PARAM_ERR_CODE
    && state_r == ST_TX && after_r == ST_IDLE) else $error("bad range accepted");
  data_after_ack_a: assert property (state_r == ST_TX && tx_ready && pend_data_r |=>
    tx_valid && tx_frame.is_data && tx_frame.sum == $past(sum_r)) else $error("no data frame");
  no_data_nak_a: assert property (tx_valid && !tx_frame.is_data &&
    tx_frame.status != ACK_CODE && tx_ready |=> !tx_valid)
    else $error("frame followed a refusal");
  data_frame_sum_a: assert property (tx_valid && tx_frame.is_data |->
    8'(tx_frame.frame_sum + SUM_DATA_LEN + tx_frame.sum[15:8] + tx_frame.sum[7:0]) == 8'h00)
    else $error("data frame checksum wrong");
  boot_param_a: assert property (sec_dat && new_boot != BOOT_REQUIRED |=>
    tx_frame.status == PARAM_ERR_CODE ##1 1'b1) else $error("bad boot accepted");
  protect_err_a: assert property (sec_dat && !sec_param_bad && sec_protect |=>
    tx_frame.status == PROTECT_CODE && !sec_op_req) else $error("protect not enforced");
  margin_code_a: assert property (state_r == ST_SEC_WRITE && sec_op_done &&
    sec_op_result == OP_MARGIN_B |=> tx_frame.status == MARGIN_B_CODE && after_r == ST_IDLE)
    else $error("margin failure code wrong");
  verify_follow_a: assert property (s_write_ok |=> s_ack_to_verify)
    else $error("verify not scheduled");
  verify_end_a: assert property (state_r == ST_SEC_VERIFY && sec_op_done |=>
    tx_valid && (tx_frame.status == ACK_CODE) == ($past(sec_op_result) == OP_OK))
    else $error("final status wrong");

endmodule // csum_sec_sequencer

/* File: testbench/prog_model.sv */
// Programmer model: sends framed bytes to the device and takes its replies
`timescale 1ns/100ps
module prog_model import seq_pkg::*; (
  // Clock
  input wire logic core_clk,
  // Frame bytes towards the device
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic rx_start,
  output logic rx_last,
  output logic rx_is_data,
  // Replies from the device
  input wire logic tx_valid,
  output logic tx_ready,
  input wire reply_t tx_frame
);
  // Waits shortened: the device does not time them, and full waits would make the run long
  localparam int GAP = TCOM_CYCLES / 1000;
  localparam int DGAP = TFD4_CYCLES / 1000;

  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    rx_start = 1'b0;
    rx_last = 1'b0;
    rx_is_data = 1'b0;
    tx_ready = 1'b0;
  end

  // Length, payload, frame sum, terminator; bad flips bits of the sum
  task automatic send(input logic d, input int n, input logic [7:0] lf,
      input logic [PAYLOAD_MAX-1:0][7:0] p, input logic [7:0] bad);
    logic [7:0] b [PAYLOAD_MAX+3];
    logic [7:0] s;
    s = lf;
    b[0] = lf;
    for (int i = 0; i < n; i++) begin
      b[i+1] = p[i];
      s = s + p[i];
    end
    b[n+1] = (8'h00 - s) ^ bad;
    b[n+2] = ETX_BYTE;
    repeat (d ? DGAP : GAP) @(negedge core_clk);
    for (int i = 0; i <= n + 2; i++) begin
      @(negedge core_clk);
      rx_valid = 1'b1;
      rx_byte = b[i];
      rx_start = (i == 0);
      rx_last = (i == n + 2);
      rx_is_data = d;
    end
    @(negedge core_clk);
    rx_valid = 1'b0;
    rx_start = 1'b0;
    rx_last = 1'b0;
    // Released line shows the inverse, never the last byte
    rx_byte = ~rx_byte;
  endtask

  // Wait for a reply under a bound, stall dly cycles, then take it
  task automatic take(input int dly, output reply_t r, output bit ok);
    int n;
    ok = 1'b0;
    r = '0;
    n = 0;
    while (tx_valid !== 1'b1 && n < 5000) begin
      @(negedge core_clk);
      n++;
    end
    if (tx_valid === 1'b1) begin
      // One edge passes first, so a ready lowered by the last call is not raised in the same step
      repeat (dly + 1) @(negedge core_clk);
      tx_ready = 1'b1;
      @(posedge core_clk);
      r = tx_frame;
      ok = 1'b1;
      @(negedge core_clk);
      tx_ready = 1'b0;
    end
  endtask
endmodule // prog_model

/* File: testbench/test_checksum_and_security_set_sequencer.sv */
// Self-checking bench for the checksum and security set sequencer
`timescale 1ns/100ps
module test_checksum_and_security_set_sequencer import seq_pkg::*; ();
  // Command codes, values arbitrary
  localparam logic [7:0] CS = 8'hB0;
  localparam logic [7:0] SC = 8'hA0;
  logic core_clk = 1'b0;
  logic reset_n;
  logic rx_valid, rx_start, rx_last, rx_is_data, tx_valid, tx_ready, busy;
  logic flash_rd_en, sec_op_req, sec_op_verify, sec_op_done;
  logic [7:0] rx_byte, flash_rd_data, cur_sec_flags;
  logic [19:0] flash_rd_addr;
  reply_t tx_frame;
  sec_set_t sec_settings, got_set;
  op_result_t sec_op_result, wr_res, vf_res;
  int err_total, total_checks, cyc, eng_cnt;

  always #2 core_clk = ~core_clk;

  csum_sec_sequencer #(.CSUM_CMD_CODE(CS), .SEC_CMD_CODE(SC)) i_csum_sec_sequencer (
    .core_clk(core_clk), .reset_n(reset_n), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_start(rx_start), .rx_last(rx_last), .rx_is_data(rx_is_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_frame(tx_frame), .flash_rd_en(flash_rd_en),
    .flash_rd_addr(flash_rd_addr), .flash_rd_data(flash_rd_data), .sec_op_req(sec_op_req),
    .sec_op_verify(sec_op_verify), .sec_settings(sec_settings), .sec_op_done(sec_op_done),
    .sec_op_result(sec_op_result), .cur_sec_flags(cur_sec_flags), .busy(busy));

  prog_model i_prog_model (.core_clk(core_clk), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_start(rx_start), .rx_last(rx_last), .rx_is_data(rx_is_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_frame(tx_frame));

  // Flash: data stands over the edge after the enable's, a changing pattern otherwise
  logic [7:0] flash_q;
  always @(negedge core_clk) begin
    flash_rd_data <= flash_q;
    flash_q <= flash_rd_en ? flash_rd_addr[7:0] ^ 8'h5A : ~flash_q;
  end

  // Security engine: done three cycles after a request, settings kept for checking
  always @(negedge core_clk) begin
    sec_op_done <= 1'b0;
    if (sec_op_req === 1'b1) begin
      eng_cnt <= 3;
      if (sec_op_verify === 1'b0) got_set <= sec_settings;
    end else if (eng_cnt > 0) begin
      eng_cnt <= eng_cnt - 1;
      if (eng_cnt == 1) begin
        sec_op_done <= 1'b1;
        sec_op_result <= sec_op_verify ? vf_res : wr_res;
      end
    end
  end

  // Cut a hang short
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One status frame: code and its frame sum
  task automatic st(input int dly, input logic [7:0] code);
    reply_t r;
    bit ok;
    i_prog_model.take(dly, r, ok);
    chk("status frame", 1'b1, ok & ~r.is_data);
    chk("status code", code, r.status);
    chk("status frame sum", 8'(8'h00 - 8'h01 - code), r.frame_sum);
  endtask

  task automatic idle(input string nm);
    @(negedge core_clk);
    chk("busy", 1'b0, busy);
    $display("%s test done", nm);
  endtask

  // Checksum command over a..e; lf and bad spoil the frame on purpose
  task automatic csum(input logic [23:0] a, e, input logic [7:0] lf, bad, code, input int dly);
    reply_t r;
    bit ok;
    logic [15:0] s;
    s = 16'h0000;
    for (int k = a; k <= e; k++) s = s + 16'(8'(k) ^ 8'h5A);
    i_prog_model.send(1'b0, 7, lf, {8'h00, e[7:0], e[15:8], e[23:16], a[7:0], a[15:8],
      a[23:16], CS}, bad);
    st(dly, code);
    if (code == ACK_CODE) begin
      i_prog_model.take(dly, r, ok);
      chk("data frame", 1'b1, ok & r.is_data);
      chk("checksum", s, r.sum);
      chk("data frame sum", 8'(8'h00 - 8'h02 - s[15:8] - s[7:0]), r.frame_sum);
    end
    idle("checksum");
  endtask

  // Security set: command, settings frame, write status, verify status
  task automatic sec(input logic [7:0] f, b, input logic [15:0] ws, we,
      input logic [7:0] bad, c2, input op_result_t wr, vf, input logic [7:0] c3);
    got_set = '0;
    wr_res = wr;
    vf_res = vf;
    i_prog_model.send(1'b0, 3, 8'h03, {40'h0, 16'h0000, SC}, 8'h00);
    st(0, ACK_CODE);
    i_prog_model.send(1'b1, 6, 8'h06, {16'h0, we[7:0], we[15:8], ws[7:0], ws[15:8], b, f},
      bad);
    st(2, c2);
    // Refused settings must never reach the engine
    chk("settings", (c2 == ACK_CODE || c2 inside {[8'h1A:8'h1C]}) ? {f, b, ws, we} : 48'h0,
      got_set);
    if (c2 == ACK_CODE) st(0, c3);
    idle("security");
  endtask

  // Security command with a spoilt frame sum: one refusal, no data frame awaited
  task automatic sec_bad();
    i_prog_model.send(1'b0, 3, 8'h03, {40'h0, 16'h0000, SC}, 8'h01);
    st(0, SUM_ERR_CODE);
    idle("security command");
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    reset_n = 1'b0;
    cur_sec_flags = 8'hFE;
    sec_op_done = 1'b0;
    sec_op_result = OP_OK;
    flash_rd_data = 8'h00;
    flash_q = 8'h00;
    eng_cnt = 0;
    err_total = 0;
    total_checks = 0;
    cyc = 0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk("reset outputs", 4'h0, {tx_valid, busy, sec_op_req, flash_rd_en});
    reset_n = 1'b1;
    csum(24'h000400, 24'h0007FF, 8'h07, 8'h00, ACK_CODE, 0);
    csum(24'h00FC00, 24'h00FFFF, 8'h07, 8'h00, ACK_CODE, 3);
    csum(24'h000400, 24'h0007FE, 8'h07, 8'h00, PARAM_ERR_CODE, 0);
    csum(24'h000401, 24'h0007FF, 8'h07, 8'h00, PARAM_ERR_CODE, 0);
    csum(24'h010000, 24'h0103FF, 8'h07, 8'h00, PARAM_ERR_CODE, 0);
    csum(24'h000400, 24'h0007FF, 8'h08, 8'h00, NACK_CODE, 0);
    csum(24'h000400, 24'h0007FF, 8'h07, 8'h01, SUM_ERR_CODE, 0);
    sec(8'hFE, 8'h01, 16'h0000, 16'h003F, 8'h00, ACK_CODE, OP_OK, OP_OK, ACK_CODE);
    for (int k = 1; k <= 3; k++) begin
      sec(8'hFE, 8'h01, 16'h0002, 16'h0002, 8'h00, 8'(8'h19 + k), op_result_t'(2'(k)), OP_OK,
        8'h00);
      sec(8'hFE, 8'h01, 16'h0000, 16'h003F, 8'h00, ACK_CODE, OP_OK, op_result_t'(2'(k)),
        8'(8'h19 + k));
    end
    sec(8'hFE, 8'h02, 16'h0000, 16'h003F, 8'h00, PARAM_ERR_CODE, OP_OK, OP_OK, 8'h00);
    sec(8'hFE, 8'h01, 16'h0005, 16'h0004, 8'h00, PARAM_ERR_CODE, OP_OK, OP_OK, 8'h00);
    sec(8'hFE, 8'h01, 16'h0000, 16'h0040, 8'h00, PARAM_ERR_CODE, OP_OK, OP_OK, 8'h00);
    sec(8'hFF, 8'h01, 16'h0000, 16'h003F, 8'h00, 8'h10, OP_OK, OP_OK, 8'h00);
    sec(8'hFE, 8'h01, 16'h0000, 16'h003F, 8'h01, SUM_ERR_CODE, OP_OK, OP_OK, 8'h00);
    sec_bad();
    conclude();
  end
endmodule // test_checksum_and_security_set_sequencer
